// ### shared/tlbta_params.svh
`ifndef TLBTA_PARAMS_SVH
`define TLBTA_PARAMS_SVH
`define TLBTA_ADDR_W 8
`define TLBTA_OFS_MAIN_SEL 8'h00
`define TLBTA_OFS_LOCK_SEL 8'h04
`define TLBTA_OFS_MAIN_TAG 8'h08
`define TLBTA_OFS_MAIN_PAP 8'h0C
`define TLBTA_OFS_MAIN_XFER 8'h10
`define TLBTA_OFS_LOCK_TAG 8'h14
`define TLBTA_OFS_LOCK_PAP 8'h18
`define TLBTA_OFS_LOCK_XFER 8'h1C
`define TLBTA_WORD_W 32
`define TLBTA_RAM_W 112
`define TLBTA_HALF_W 56
`define TLBTA_ROW_W 5
`define TLBTA_ROWS 32
`define TLBTA_LOCK_W 3
`define TLBTA_LOCK_ENTRIES 8
`define TLBTA_WAY_BIT 31
`define TLBTA_MIDX_LO 10
`define TLBTA_LIDX_LO 26
`define TLBTA_ADR_W 22
`define TLBTA_SIZE_W 4
`define TLBTA_ATTR_W 8
`define TLBTA_VALID_BIT 4
`define TLBTA_TAG_SBZ 5'h00
`define TLBTA_PAP_SBZ 2'h0
`define TLBTA_WE_NONE 4'h0
`define TLBTA_WE_WAY0 4'h3
`define TLBTA_WE_WAY1 4'hC
`define TLBTA_STRB_ALL 4'hF
`define TLBTA_RESP_OKAY 2'h0
`define TLBTA_RESP_SLVERR 2'h2
`endif

// ### shared/tlbta_pkg.sv
`include "tlbta_params.svh"
`default_nettype none
package tlbta_pkg;
   typedef logic [`TLBTA_WORD_W-1:0] tlbta_word_type;
   typedef logic [`TLBTA_HALF_W-1:0] tlbta_half_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RAM_WR = 3'b001,
      ST_RAM_RD = 3'b010,
      ST_RAM_CAP = 3'b011,
      ST_RAM_DONE = 3'b100
   } tlbta_state_type;

   // One way's copy of an entry: tag, size, physical page, domain/permission/C/B
   function automatic tlbta_half_type tlbta_pack(input tlbta_word_type tag,
                                                 input tlbta_word_type pap);
      return {tag[`TLBTA_WORD_W-1 -: `TLBTA_ADR_W], tag[`TLBTA_SIZE_W-1:0],
              pap[`TLBTA_WORD_W-1 -: `TLBTA_ADR_W], pap[`TLBTA_ATTR_W-1:0]};
   endfunction : tlbta_pack

   function automatic tlbta_word_type tlbta_half_tag(input tlbta_half_type h,
                                                     input logic valid);
      logic [`TLBTA_ADR_W-1:0] t_adr;
      logic [`TLBTA_SIZE_W-1:0] t_size;
      logic [`TLBTA_ADR_W-1:0] p_adr;
      logic [`TLBTA_ATTR_W-1:0] p_attr;
      {t_adr, t_size, p_adr, p_attr} = h;
      return {t_adr, `TLBTA_TAG_SBZ, valid, t_size};
   endfunction : tlbta_half_tag

   function automatic tlbta_word_type tlbta_half_pap(input tlbta_half_type h);
      logic [`TLBTA_ADR_W-1:0] t_adr;
      logic [`TLBTA_SIZE_W-1:0] t_size;
      logic [`TLBTA_ADR_W-1:0] p_adr;
      logic [`TLBTA_ATTR_W-1:0] p_attr;
      {t_adr, t_size, p_adr, p_attr} = h;
      return {p_adr, `TLBTA_PAP_SBZ, p_attr};
   endfunction : tlbta_half_pap
endpackage : tlbta_pkg
`default_nettype wire

// ### hw/tlbta_axil_slave.sv
`include "tlbta_params.svh"
`default_nettype none
module tlbta_axil_slave
   import tlbta_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write address and data channels
   input wire logic [`TLBTA_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [`TLBTA_WORD_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read channels
   input wire logic [`TLBTA_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [`TLBTA_WORD_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Core side
   output logic wr_req,
   output logic [`TLBTA_ADDR_W-1:0] wr_addr,
   output logic [`TLBTA_WORD_W-1:0] wr_data,
   input wire logic wr_ack,
   input wire logic wr_err,
   output logic rd_req,
   output logic [`TLBTA_ADDR_W-1:0] rd_addr,
   input wire logic rd_ack,
   input wire logic rd_err,
   input wire logic [`TLBTA_WORD_W-1:0] rd_data
);
   logic aw_full;
   logic w_full;
   logic ar_full;
   logic [3:0] strb;
   logic strb_bad;

   assign awready = !aw_full && !bvalid;
   assign wready = !w_full && !bvalid;
   assign arready = !ar_full && !rvalid;
   assign rd_req = ar_full;
   // Partial strobes would need a read-modify-write; refused instead
   assign wr_req = aw_full && w_full && !bvalid && (strb == `TLBTA_STRB_ALL);
   assign strb_bad = aw_full && w_full && !bvalid && (strb != `TLBTA_STRB_ALL);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_full <= 1'b0;
         wr_addr <= '0;
      end else if (awvalid && awready) begin
         aw_full <= 1'b1;
         wr_addr <= {awaddr[`TLBTA_ADDR_W-1:2], 2'h0};
      end else if (wr_ack || strb_bad) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         w_full <= 1'b0;
         wr_data <= '0;
         strb <= `TLBTA_WE_NONE;
      end else if (wvalid && wready) begin
         w_full <= 1'b1;
         wr_data <= wdata;
         strb <= wstrb;
      end else if (wr_ack || strb_bad) begin
         w_full <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= `TLBTA_RESP_OKAY;
      end else if (wr_ack || strb_bad) begin
         bvalid <= 1'b1;
         bresp <= (strb_bad || wr_err) ? `TLBTA_RESP_SLVERR : `TLBTA_RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ar_full <= 1'b0;
         rd_addr <= '0;
      end else if (arvalid && arready) begin
         ar_full <= 1'b1;
         rd_addr <= {araddr[`TLBTA_ADDR_W-1:2], 2'h0};
      end else if (rd_ack) begin
         ar_full <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `TLBTA_RESP_OKAY;
      end else if (rd_ack) begin
         rvalid <= 1'b1;
         rdata <= rd_data;
         rresp <= rd_err ? `TLBTA_RESP_SLVERR : `TLBTA_RESP_OKAY;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : tlbta_axil_slave
`default_nettype wire

// ### hw/tlbta_lock_store.sv
`include "tlbta_params.svh"
`default_nettype none
module tlbta_lock_store
   import tlbta_pkg::*;
#(
   parameter int ENTRIES = `TLBTA_LOCK_ENTRIES,
   parameter int IDX_W = `TLBTA_LOCK_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Commit port
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] idx,
   input wire tlbta_word_type tag_in,
   input wire tlbta_word_type pap_in,
   // Read port, same index
   output tlbta_word_type tag_out,
   output tlbta_word_type pap_out
);
   tlbta_word_type tag_mem [ENTRIES];
   tlbta_word_type pap_mem [ENTRIES];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < ENTRIES; i++) begin
            tag_mem[i] <= '0;
            pap_mem[i] <= '0;
         end
      end else if (wr_en) begin
         tag_mem[idx] <= tag_in;
         pap_mem[idx] <= pap_in;
      end
   end

   assign tag_out = tag_mem[idx];
   assign pap_out = pap_mem[idx];
endmodule : tlbta_lock_store
`default_nettype wire

// ### hw/tlbta_top.sv
`include "tlbta_params.svh"
`default_nettype none
module tlbta_top
   import tlbta_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Register bus write
   input wire logic [`TLBTA_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [`TLBTA_WORD_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // Register bus read
   input wire logic [`TLBTA_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [`TLBTA_WORD_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Main table data RAM
   output logic [`TLBTA_RAM_W-1:0] TLB_RAM_WRITE_BUS,
   output logic TLB_RAM_SELECT,
   output logic [3:0] TLB_RAM_LANE_WRITE_ENABLES,
   output logic [`TLBTA_ROW_W-1:0] TLB_RAM_ROW_INDEX,
   output logic TLB_RAM_OUTPUT_ENABLE,
   input wire logic [`TLBTA_RAM_W-1:0] TLB_RAM_READ_BUS
);
   logic wr_req;
   logic [`TLBTA_ADDR_W-1:0] wr_addr;
   tlbta_word_type wr_data;
   logic wr_ack;
   logic wr_err;
   logic rd_req;
   logic [`TLBTA_ADDR_W-1:0] rd_addr;
   logic rd_ack;
   logic rd_err;
   tlbta_word_type rd_data;

   tlbta_state_type state;
   tlbta_state_type next_state;
   logic sel_way;
   logic [`TLBTA_ROW_W-1:0] sel_row;
   logic [`TLBTA_LOCK_W-1:0] lock_idx;
   tlbta_word_type main_tag_stage;
   tlbta_word_type main_pap_stage;
   tlbta_word_type lock_tag_stage;
   tlbta_word_type lock_pap_stage;
   logic [`TLBTA_ROWS-1:0] valid_way0;
   logic [`TLBTA_ROWS-1:0] valid_way1;
   tlbta_half_type ram_cap;
   logic rd_want_pap;
   logic idle;
   logic wr_take;
   logic rd_take;
   logic rd_is_ram;
   logic lock_commit;
   tlbta_word_type lock_tag_out;
   tlbta_word_type lock_pap_out;

   tlbta_axil_slave u_bus (
      .clk(CLK),
      .rst_n(RST_N),
      .awaddr(S_AXI_AWADDR),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .bresp(S_AXI_BRESP),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .araddr(S_AXI_ARADDR),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .wr_req(wr_req),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_ack(wr_ack),
      .wr_err(wr_err),
      .rd_req(rd_req),
      .rd_addr(rd_addr),
      .rd_ack(rd_ack),
      .rd_err(rd_err),
      .rd_data(rd_data)
   );

   tlbta_lock_store u_lock (
      .clk(CLK),
      .rst_n(RST_N),
      .wr_en(lock_commit),
      .idx(lock_idx),
      .tag_in(lock_tag_stage),
      .pap_in(lock_pap_stage),
      .tag_out(lock_tag_out),
      .pap_out(lock_pap_out)
   );

   // Writes win over reads; one table operation at a time
   assign idle = (state == ST_IDLE);
   assign wr_take = idle && wr_req;
   assign wr_ack = wr_take;
   assign rd_is_ram = (rd_addr == `TLBTA_OFS_MAIN_TAG) || (rd_addr == `TLBTA_OFS_MAIN_PAP);
   assign rd_take = idle && !wr_req && rd_req;
   assign lock_commit = wr_take && (wr_addr == `TLBTA_OFS_LOCK_XFER);
   assign TLB_RAM_OUTPUT_ENABLE = 1'b1;

   always_comb begin
      case (wr_addr)
         `TLBTA_OFS_MAIN_SEL, `TLBTA_OFS_LOCK_SEL, `TLBTA_OFS_MAIN_TAG, `TLBTA_OFS_MAIN_PAP,
         `TLBTA_OFS_MAIN_XFER, `TLBTA_OFS_LOCK_TAG, `TLBTA_OFS_LOCK_PAP,
         `TLBTA_OFS_LOCK_XFER: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end

   // Read answers: table reads of the main RAM answer from the captured row
   always_comb begin
      rd_ack = rd_take && !rd_is_ram;
      rd_err = 1'b0;
      rd_data = '0;
      if (state == ST_RAM_DONE) begin
         rd_ack = 1'b1;
         if (rd_want_pap) begin
            rd_data = tlbta_half_pap(ram_cap);
         end else begin
            rd_data = tlbta_half_tag(ram_cap,
               sel_way ? valid_way1[sel_row] : valid_way0[sel_row]);
         end
      end else begin
         case (rd_addr)
            `TLBTA_OFS_MAIN_SEL: begin
               rd_data[`TLBTA_WAY_BIT] = sel_way;
               rd_data[`TLBTA_MIDX_LO +: `TLBTA_ROW_W] = sel_row;
            end
            `TLBTA_OFS_LOCK_SEL: rd_data[`TLBTA_LIDX_LO +: `TLBTA_LOCK_W] = lock_idx;
            `TLBTA_OFS_LOCK_TAG: rd_data = lock_tag_out;
            `TLBTA_OFS_LOCK_PAP: rd_data = lock_pap_out;
            `TLBTA_OFS_MAIN_TAG, `TLBTA_OFS_MAIN_PAP, `TLBTA_OFS_MAIN_XFER,
            `TLBTA_OFS_LOCK_XFER: rd_data = '0;
            default: rd_err = 1'b1;
         endcase
      end
   end

   // Selection: must-be-zero bits are dropped
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sel_way <= 1'b0;
         sel_row <= '0;
         lock_idx <= '0;
      end else if (wr_take && wr_addr == `TLBTA_OFS_MAIN_SEL) begin
         sel_way <= wr_data[`TLBTA_WAY_BIT];
         sel_row <= wr_data[`TLBTA_MIDX_LO +: `TLBTA_ROW_W];
      end else if (wr_take && wr_addr == `TLBTA_OFS_LOCK_SEL) begin
         lock_idx <= wr_data[`TLBTA_LIDX_LO +: `TLBTA_LOCK_W];
      end
   end

   // Staging registers hold until overwritten; commits do not clear them
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         main_tag_stage <= '0;
         main_pap_stage <= '0;
         lock_tag_stage <= '0;
         lock_pap_stage <= '0;
      end else if (wr_take) begin
         case (wr_addr)
            `TLBTA_OFS_MAIN_TAG: main_tag_stage <= wr_data;
            `TLBTA_OFS_MAIN_PAP: main_pap_stage <= wr_data;
            `TLBTA_OFS_LOCK_TAG: lock_tag_stage <= wr_data;
            `TLBTA_OFS_LOCK_PAP: lock_pap_stage <= wr_data;
            default: main_tag_stage <= main_tag_stage;
         endcase
      end
   end

   // The RAM row keeps no valid flag, so it lives here per way and row
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         valid_way0 <= '0;
         valid_way1 <= '0;
      end else if (wr_take && wr_addr == `TLBTA_OFS_MAIN_XFER) begin
         if (sel_way) begin
            valid_way1[sel_row] <= main_tag_stage[`TLBTA_VALID_BIT];
         end else begin
            valid_way0[sel_row] <= main_tag_stage[`TLBTA_VALID_BIT];
         end
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (wr_take && wr_addr == `TLBTA_OFS_MAIN_XFER) begin
               next_state = ST_RAM_WR;
            end else if (rd_take && rd_is_ram) begin
               next_state = ST_RAM_RD;
            end
         end
         ST_RAM_WR: next_state = ST_IDLE;
         ST_RAM_RD: next_state = ST_RAM_CAP;
         ST_RAM_CAP: next_state = ST_RAM_DONE;
         ST_RAM_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // RAM port: select is high for exactly one cycle per access
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         TLB_RAM_SELECT <= 1'b0;
         TLB_RAM_LANE_WRITE_ENABLES <= `TLBTA_WE_NONE;
         TLB_RAM_ROW_INDEX <= '0;
         TLB_RAM_WRITE_BUS <= '0;
         rd_want_pap <= 1'b0;
      end else if (idle && next_state == ST_RAM_WR) begin
         TLB_RAM_SELECT <= 1'b1;
         TLB_RAM_LANE_WRITE_ENABLES <= sel_way ? `TLBTA_WE_WAY1 : `TLBTA_WE_WAY0;
         TLB_RAM_ROW_INDEX <= sel_row;
         TLB_RAM_WRITE_BUS <= {tlbta_pack(main_tag_stage, main_pap_stage),
                               tlbta_pack(main_tag_stage, main_pap_stage)};
      end else if (idle && next_state == ST_RAM_RD) begin
         TLB_RAM_SELECT <= 1'b1;
         TLB_RAM_LANE_WRITE_ENABLES <= `TLBTA_WE_NONE;
         TLB_RAM_ROW_INDEX <= sel_row;
         rd_want_pap <= (rd_addr == `TLBTA_OFS_MAIN_PAP);
      end else begin
         TLB_RAM_SELECT <= 1'b0;
         TLB_RAM_LANE_WRITE_ENABLES <= `TLBTA_WE_NONE;
      end
   end

   // Read bus is looked at only in the capture cycle of a read
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ram_cap <= '0;
      end else if (state == ST_RAM_CAP) begin
         ram_cap <= sel_way ? TLB_RAM_READ_BUS[`TLBTA_RAM_W-1 -: `TLBTA_HALF_W]
                            : TLB_RAM_READ_BUS[`TLBTA_HALF_W-1:0];
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   oe_held_a: assert property (TLB_RAM_OUTPUT_ENABLE)
      else $error("RAM output enable dropped");
   write_copy_a: assert property (TLB_RAM_SELECT && TLB_RAM_LANE_WRITE_ENABLES != 4'h0
      |-> TLB_RAM_WRITE_BUS[111:56] == TLB_RAM_WRITE_BUS[55:0])
      else $error("Halves of write bus differ");
   write_layout_a: assert property (TLB_RAM_SELECT && TLB_RAM_LANE_WRITE_ENABLES != 4'h0
      |-> TLB_RAM_WRITE_BUS[111:90] == main_tag_stage[31:10]
          && TLB_RAM_WRITE_BUS[89:86] == main_tag_stage[3:0]
          && TLB_RAM_WRITE_BUS[29:8] == main_pap_stage[31:10]
          && TLB_RAM_WRITE_BUS[7:0] == main_pap_stage[7:0])
      else $error("Write bus field layout wrong");
   way_lanes_a: assert property (TLB_RAM_SELECT && TLB_RAM_LANE_WRITE_ENABLES != 4'h0
      |-> TLB_RAM_LANE_WRITE_ENABLES == (sel_way ? 4'hC : 4'h3)
          && TLB_RAM_ROW_INDEX == sel_row)
      else $error("Lanes or row do not match selection");
   commit_pulse_a: assert property (wr_take && wr_addr == `TLBTA_OFS_MAIN_XFER
      |=> TLB_RAM_SELECT && TLB_RAM_LANE_WRITE_ENABLES != 4'h0 ##1 !TLB_RAM_SELECT)
      else $error("Commit did not make one RAM write");
   stage_quiet_a: assert property (wr_take && wr_addr != `TLBTA_OFS_MAIN_XFER
      |=> !TLB_RAM_SELECT)
      else $error("RAM touched without commit");
   read_seq_a: assert property (rd_take && rd_is_ram
      |=> TLB_RAM_SELECT && TLB_RAM_LANE_WRITE_ENABLES == 4'h0
          ##1 state == ST_RAM_CAP ##1 rd_ack)
      else $error("RAM read sequence broken");
   tag_hold_a: assert property (!(wr_take && wr_addr == `TLBTA_OFS_MAIN_TAG)
      |=> $stable(main_tag_stage))
      else $error("Staged tag changed");
   lock_commit_a: assert property (lock_commit
      |=> lock_tag_out == $past(lock_tag_stage) && lock_pap_out == $past(lock_pap_stage))
      else $error("Lockdown commit lost");
   lock_sel_a: assert property (wr_take && wr_addr == `TLBTA_OFS_LOCK_SEL
      |=> lock_idx == $past(wr_data[28:26]))
      else $error("Lockdown index not taken from 28:26");
endmodule : tlbta_top
`default_nettype wire

// ### test/tlbta_ram_model.sv
`default_nettype none
module tlbta_ram_model (
   // Clock
   input wire logic clk,
   // Access port
   input wire logic sel,
   input wire logic [3:0] we,
   input wire logic [4:0] idx,
   input wire logic [111:0] wbus,
   output logic [111:0] rbus = '0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [111:0] mem [32] = '{default: '0};
   // Bit 56 sits in no lane, so it keeps its power-up value
   always @(posedge clk) begin
      if (sel) begin
         if (we[0]) mem[idx][29:0] <= wbus[29:0];
         if (we[1]) mem[idx][55:30] <= wbus[55:30];
         if (we[2]) mem[idx][85:57] <= wbus[85:57];
         if (we[3]) mem[idx][111:86] <= wbus[111:86];
         rbus <= mem[idx];
      end else begin
         // Always driven, but scrambled outside the read slot to expose late sampling
         rbus <= ~rbus;
      end
   end
endmodule : tlbta_ram_model
`default_nettype wire

// ### test/tb_tlb_test_ram_access.sv
`default_nettype none
module tb_tlb_test_ram_access
   import tlbta_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK, RST_N;
   logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB, TLB_RAM_LANE_WRITE_ENABLES, seen_we;
   logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
   logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic [111:0] TLB_RAM_WRITE_BUS, TLB_RAM_READ_BUS, seen_wbus;
   logic TLB_RAM_SELECT, TLB_RAM_OUTPUT_ENABLE;
   logic [4:0] TLB_RAM_ROW_INDEX, seen_row;
   int n_fail = 0;
   int n_tests = 0;
   int n_sel = 0;
   logic [3:0] sz [5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'hB};

   tlbta_top dut_u (.CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
      .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
      .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .TLB_RAM_WRITE_BUS,
      .TLB_RAM_SELECT, .TLB_RAM_LANE_WRITE_ENABLES, .TLB_RAM_ROW_INDEX,
      .TLB_RAM_OUTPUT_ENABLE, .TLB_RAM_READ_BUS);
   tlbta_ram_model ram_u (.clk(CLK), .sel(TLB_RAM_SELECT), .we(TLB_RAM_LANE_WRITE_ENABLES),
      .idx(TLB_RAM_ROW_INDEX), .wbus(TLB_RAM_WRITE_BUS), .rbus(TLB_RAM_READ_BUS));

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [111:0] g, input logic [111:0] e, input string m);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk

   // Every RAM access the block launches, as the RAM sees it
   always @(negedge CLK) begin
      if (TLB_RAM_SELECT === 1'b1) begin
         n_sel++;
         seen_we = TLB_RAM_LANE_WRITE_ENABLES;
         seen_row = TLB_RAM_ROW_INDEX;
         seen_wbus = TLB_RAM_WRITE_BUS;
      end
   end
   always @(negedge CLK) begin
      if (TLB_RAM_OUTPUT_ENABLE !== 1'b1) chk(1'b0, 1'b1, "output enable dropped");
   end

   // Readies are combinational, so they are judged at the falling edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                     input logic [1:0] e = 2'h0);
      logic ta, tw, tb;
      tb = 1'b0;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      while (!tb) begin
         @(negedge CLK);
         ta = S_AXI_AWVALID && S_AXI_AWREADY === 1'b1;
         tw = S_AXI_WVALID && S_AXI_WREADY === 1'b1;
         tb = S_AXI_BVALID === 1'b1;
         if (tb) chk(S_AXI_BRESP, e, "write response");
         @(posedge CLK);
         if (ta) S_AXI_AWVALID <= 1'b0;
         if (tw) S_AXI_WVALID <= 1'b0;
         if (tb) S_AXI_BREADY <= 1'b0;
      end
      // One spare edge, so the next call never re-raises a ready in this time step
      @(negedge CLK);
      chk(S_AXI_BVALID, 1'b0, "write response not withdrawn");
      @(posedge CLK);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      logic ta, tr;
      tr = 1'b0;
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      while (!tr) begin
         @(negedge CLK);
         ta = S_AXI_ARVALID && S_AXI_ARREADY === 1'b1;
         tr = S_AXI_RVALID === 1'b1;
         if (tr) chk({S_AXI_RRESP, S_AXI_RDATA}, {er, e}, "read data or response");
         @(posedge CLK);
         if (ta) S_AXI_ARVALID <= 1'b0;
         if (tr) S_AXI_RREADY <= 1'b0;
      end
      @(negedge CLK);
      chk(S_AXI_RVALID, 1'b0, "read answer not withdrawn");
      @(posedge CLK);
   endtask : rd

   task automatic t_main(input logic way, input logic [4:0] row, input logic [31:0] tag,
                         input logic [31:0] pap);
      logic [55:0] h;
      int s0;
      h = {tag[31:10], tag[3:0], pap[31:10], pap[7:0]};
      wr(8'h00, {way, 16'hFFFF, row, 10'h3FF});
      rd(8'h00, {way, 16'h0000, row, 10'h000});
      s0 = n_sel;
      wr(8'h08, tag);
      wr(8'h0C, pap);
      chk(n_sel, s0, "staging touched RAM");
      wr(8'h10, 32'h0000_0000);
      @(posedge CLK);
      chk(n_sel, s0 + 1, "commit select count");
      chk(seen_we, way ? 4'hC : 4'h3, "lane enables");
      chk(seen_row, row, "row index");
      chk(seen_wbus, {h, h}, "write bus layout");
      rd(8'h08, {tag[31:10], 5'h00, tag[4], tag[3:0]});
      // Upper copy of the bufferable bit lives in no lane and reads back as its power-up 0
      rd(8'h0C, {pap[31:10], 2'h0, pap[7:1], way ? 1'b0 : pap[0]});
      chk(n_sel, s0 + 3, "read select count");
      chk(seen_we, 4'h0, "read wrote lanes");
      chk(seen_row, row, "read row index");
   endtask : t_main

   task automatic t_lock;
      int s0;
      s0 = n_sel;
      wr(8'h04, {3'h7, 3'h5, 26'h3FF_FFFF});
      wr(8'h14, 32'hABCD_E411);
      wr(8'h18, 32'h1234_54F3);
      wr(8'h1C, 32'h0000_0000);
      wr(8'h04, {3'h0, 3'h2, 26'h000_0000});
      wr(8'h14, 32'h5555_5C07);
      wr(8'h18, 32'h0F0F_0C0A);
      wr(8'h1C, 32'h0000_0000);
      wr(8'h14, 32'hFFFF_FC1B);
      rd(8'h14, 32'h5555_5C07);
      rd(8'h18, 32'h0F0F_0C0A);
      wr(8'h04, {3'h7, 3'h5, 26'h3FF_FFFF});
      rd(8'h14, 32'hABCD_E411);
      rd(8'h18, 32'h1234_54F3);
      chk(n_sel, s0, "lockdown used main RAM");
   endtask : t_lock

   task automatic t_errors;
      wr(8'h00, 32'h0000_0C00);
      wr(8'h00, 32'h8000_7C00, 4'h3, 2'h2);
      rd(8'h00, 32'h0000_0C00);
      wr(8'h20, 32'h0000_0001, 4'hF, 2'h2);
      rd(8'h20, 32'h0000_0000, 2'h2);
      rd(8'h10, 32'h0000_0000);
   endtask : t_errors

   initial begin
      repeat (5000) @(posedge CLK);
      n_fail++;
      end_of_test();
   end

   initial begin
      RST_N <= 1'b0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} <= '0;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} <= '0;
      repeat (4) @(posedge CLK);
      RST_N <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         t_main(~i[0], 5'(31 - i * 7), {22'(32'h3A5C71 + i * 32'h1111), 5'h00, 1'(i != 2),
            sz[i]}, {22'(32'h15A3C + i * 32'h2C01), 2'h0, 8'(8'hA5 + i * 8'h13)});
      end
      t_main(1'b0, 5'd31, 32'h0123_4C03, 32'h89AB_CC5B);
      wr(8'h00, 32'h8000_7C00);
      rd(8'h08, 32'hE971_C411);
      t_lock();
      t_errors();
      end_of_test();
   end
endmodule : tb_tlb_test_ram_access
`default_nettype wire
